/* File: core/cfeu_cond_eval.sv */
`timescale 1ns/1ps
module cfeu_cond_eval
  import cfeu_pkg::*;
(
  input  wire logic [3:0] cond,
  input  wire logic [4:0] flags,
  output logic            cond_true
);
  logic z_f;
  logic s_f;
  logic ov_f;
  logic cy_f;
  logic sat_f;

  assign z_f   = flags[CFEU_F_Z];
  assign s_f   = flags[CFEU_F_S];
  assign ov_f  = flags[CFEU_F_OV];
  assign cy_f  = flags[CFEU_F_CY];
  assign sat_f = flags[CFEU_F_SAT];

  always_comb begin
    case (cond)
      CFEU_CC_OV:     cond_true = ov_f;
      CFEU_CC_NOV:    cond_true = ~ov_f;
      CFEU_CC_CY:     cond_true = cy_f;
      CFEU_CC_NC:     cond_true = ~cy_f;
      CFEU_CC_Z:      cond_true = z_f;
      CFEU_CC_NZ:     cond_true = ~z_f;
      CFEU_CC_NH:     cond_true = cy_f | z_f;
      CFEU_CC_H:      cond_true = ~(cy_f | z_f);
      CFEU_CC_S:      cond_true = s_f;
      CFEU_CC_NS:     cond_true = ~s_f;
      CFEU_CC_ALWAYS: cond_true = 1'b1;
      CFEU_CC_SAT:    cond_true = sat_f;
      CFEU_CC_LT:     cond_true = s_f ^ ov_f;
      CFEU_CC_GE:     cond_true = ~(s_f ^ ov_f);
      CFEU_CC_LE:     cond_true = (s_f ^ ov_f) | z_f;
      default:        cond_true = ~((s_f ^ ov_f) | z_f);
    endcase
  end
endmodule

/* File: core/cfeu_extend.sv */
`timescale 1ns/1ps
module cfeu_extend
  import cfeu_pkg::*;
(
  input  wire logic [31:0] din,
  input  wire logic [1:0]  size,
  input  wire logic        signed_ext,
  output logic      [31:0] dout
);
  always_comb begin
    if (size == CFEU_SZ_BYTE) begin
      dout = signed_ext ? {{24{din[7]}}, din[7:0]}
                        : {24'h000000, din[7:0]};
    end else if (size == CFEU_SZ_HALF) begin
      dout = signed_ext ? {{16{din[15]}}, din[15:0]}
                        : {16'h0000, din[15:0]};
    end else begin
      dout = din;
    end
  end
endmodule

/* File: core/cfeu_pkg.sv */
package cfeu_pkg;

  // condition codes
  localparam logic [3:0] CFEU_CC_OV     = 4'h0;
  localparam logic [3:0] CFEU_CC_CY     = 4'h1;
  localparam logic [3:0] CFEU_CC_Z      = 4'h2;
  localparam logic [3:0] CFEU_CC_NH     = 4'h3;
  localparam logic [3:0] CFEU_CC_S      = 4'h4;
  localparam logic [3:0] CFEU_CC_ALWAYS = 4'h5;
  localparam logic [3:0] CFEU_CC_LT     = 4'h6;
  localparam logic [3:0] CFEU_CC_LE     = 4'h7;
  localparam logic [3:0] CFEU_CC_NOV    = 4'h8;
  localparam logic [3:0] CFEU_CC_NC     = 4'h9;
  localparam logic [3:0] CFEU_CC_NZ     = 4'ha;
  localparam logic [3:0] CFEU_CC_H      = 4'hb;
  localparam logic [3:0] CFEU_CC_NS     = 4'hc;
  localparam logic [3:0] CFEU_CC_SAT    = 4'hd;
  localparam logic [3:0] CFEU_CC_GE     = 4'he;
  localparam logic [3:0] CFEU_CC_GT     = 4'hf;

  // flag vector bit positions
  localparam int CFEU_FLAG_W   = 5;
  localparam int CFEU_F_Z      = 0;
  localparam int CFEU_F_S      = 1;
  localparam int CFEU_F_OV     = 2;
  localparam int CFEU_F_CY     = 3;
  localparam int CFEU_F_SAT    = 4;
  localparam logic [4:0] CFEU_FLAG_RST = 5'h00;

  // saturation bounds
  localparam logic [31:0] CFEU_SAT_MAX = 32'h7fffffff;
  localparam logic [31:0] CFEU_SAT_MIN = 32'h80000000;

  // extension source widths
  localparam logic [1:0] CFEU_SZ_BYTE = 2'h0;
  localparam logic [1:0] CFEU_SZ_HALF = 2'h1;
  localparam logic [1:0] CFEU_SZ_WORD = 2'h2;

  // flag update policy per flag
  typedef enum logic [1:0] {
    CFEU_POL_KEEP,
    CFEU_POL_CLEAR,
    CFEU_POL_RESULT,
    CFEU_POL_RESTORE
  } cfeu_pol_t;

  // pipeline timing counter width
  localparam int CFEU_TCNT_W = 4;

endpackage

/* File: core/cfeu_top.sv */
`timescale 1ns/1ps
module cfeu_top
  import cfeu_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // condition evaluation
  input  wire logic [3:0]             cond_code,
  output logic                        cond_true_r,
  // flag update
  input  wire logic                   flag_upd,
  input  wire logic [9:0]             flag_policy,
  input  wire logic [4:0]             result_flags,
  input  wire logic                   flag_save,
  output logic      [4:0]             flags_r,
  output logic      [4:0]             saved_flags_r,
  // saturation
  input  wire logic [63:0]            sat_in,
  output logic      [31:0]            sat_out_r,
  output logic                        sat_hit_r,
  // extension
  input  wire logic [31:0]            ext_in,
  input  wire logic [1:0]             ext_size,
  input  wire logic                   ext_signed,
  output logic      [31:0]            ext_out_r,
  // memory path
  input  wire logic                   mem_rd,
  input  wire logic                   mem_wr,
  input  wire logic [31:0]            mem_addr,
  input  wire logic [1:0]             mem_size,
  input  wire logic                   mem_signed,
  input  wire logic [31:0]            mem_rdata,
  input  wire logic                   bit_wr,
  input  wire logic [2:0]             bit_num,
  input  wire logic                   bit_val,
  output logic      [31:0]            load_data_r,
  output logic                        load_zero_r,
  output logic      [31:0]            store_data_r,
  output logic      [3:0]             store_be_r,
  output logic                        store_valid_r,
  // pipeline timing
  input  wire logic                   instr_valid,
  input  wire logic [7:0]             instr_id,
  input  wire logic [CFEU_TCNT_W-1:0] issue_cyc,
  input  wire logic [CFEU_TCNT_W-1:0] repeat_cyc,
  input  wire logic [CFEU_TCNT_W-1:0] latency_cyc,
  output logic                        issue_ok_r,
  output logic                        repeat_ok_r,
  output logic                        result_ok_r
);

  ////////////////////////////////////////////////////////////////////
  // condition evaluation
  logic cond_now;

  cfeu_cond_eval u_cond (
    .cond      (cond_code),
    .flags     (flags_r),
    .cond_true (cond_now)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cond_true_r <= 1'b0;
    end else begin
      cond_true_r <= cond_now;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flag update policies
  logic [4:0] flags_nxt;

  generate
    for (genvar f = 0; f < CFEU_FLAG_W; f++) begin : g_flag
      cfeu_pol_t pol;
      logic      pick;

      assign pol = cfeu_pol_t'(flag_policy[2*f +: 2]);

      always_comb begin
        case (pol)
          CFEU_POL_CLEAR:   pick = 1'b0;
          CFEU_POL_RESULT:  pick = result_flags[f];
          CFEU_POL_RESTORE: pick = saved_flags_r[f];
          default:          pick = flags_r[f];
        endcase
      end

      // idle cycles keep the flag
      assign flags_nxt[f] = flag_upd ? pick : flags_r[f];
    end
  endgenerate

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flags_r <= CFEU_FLAG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      saved_flags_r <= CFEU_FLAG_RST;
    end else if (flag_save) begin
      saved_flags_r <= flags_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // saturation
  logic signed [63:0] sat_s;
  logic        [31:0] sat_nxt;
  logic               hit_nxt;

  assign sat_s = signed'(sat_in);

  always_comb begin
    if (sat_s >= signed'({32'h00000000, CFEU_SAT_MAX})) begin
      sat_nxt = CFEU_SAT_MAX;
      hit_nxt = 1'b1;
    end else if (sat_s <= signed'({32'hffffffff, CFEU_SAT_MIN})) begin
      sat_nxt = CFEU_SAT_MIN;
      hit_nxt = 1'b1;
    end else begin
      sat_nxt = sat_in[31:0];
      hit_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sat_out_r <= 32'h00000000;
    end else begin
      sat_out_r <= sat_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sat_hit_r <= 1'b0;
    end else begin
      sat_hit_r <= hit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operand extension
  logic [31:0] ext_nxt;

  cfeu_extend u_ext (
    .din        (ext_in),
    .size       (ext_size),
    .signed_ext (ext_signed),
    .dout       (ext_nxt)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_out_r <= 32'h00000000;
    end else begin
      ext_out_r <= ext_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sized loads and bit store
  logic [31:0] lane_data;
  logic [31:0] load_nxt;
  logic [4:0]  byte_shift;
  logic [4:0]  half_shift;
  logic [7:0]  bit_byte;
  logic [7:0]  bit_new;
  logic [31:0] wr_data;
  logic [3:0]  wr_be;

  assign byte_shift = {mem_addr[1:0], 3'h0};
  assign half_shift = {mem_addr[1], 4'h0};

  // align the addressed lane down to bit 0
  always_comb begin
    if (mem_size == CFEU_SZ_BYTE) begin
      lane_data = mem_rdata >> byte_shift;
    end else if (mem_size == CFEU_SZ_HALF) begin
      lane_data = mem_rdata >> half_shift;
    end else begin
      lane_data = mem_rdata;
    end
  end

  cfeu_extend u_ld_ext (
    .din        (lane_data),
    .size       (mem_size),
    .signed_ext (mem_signed),
    .dout       (load_nxt)
  );

  // bit ops use the addressed byte whatever the access size
  assign bit_byte = mem_rdata[byte_shift +: 8];

  // read-modify-write of a single bit within the byte
  always_comb begin
    bit_new          = bit_byte;
    bit_new[bit_num] = bit_val;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      load_data_r <= 32'h00000000;
    end else if (mem_rd) begin
      load_data_r <= load_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      load_zero_r <= 1'b0;
    end else if (mem_rd) begin
      load_zero_r <= ~bit_byte[bit_num];
    end
  end

  // sized store lanes, data replicated over the word
  always_comb begin
    if (mem_size == CFEU_SZ_BYTE) begin
      wr_data = {4{ext_in[7:0]}};
      wr_be   = 4'h1 << mem_addr[1:0];
    end else if (mem_size == CFEU_SZ_HALF) begin
      wr_data = {2{ext_in[15:0]}};
      wr_be   = mem_addr[1] ? 4'hc : 4'h3;
    end else begin
      wr_data = ext_in;
      wr_be   = 4'hf;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      store_valid_r <= 1'b0;
    end else begin
      store_valid_r <= bit_wr | mem_wr;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      store_data_r <= 32'h00000000;
    end else if (bit_wr) begin
      store_data_r <= {4{bit_new}};
    end else if (mem_wr) begin
      store_data_r <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      store_be_r <= 4'h0;
    end else if (bit_wr) begin
      store_be_r <= 4'h1 << mem_addr[1:0];
    end else if (mem_wr) begin
      store_be_r <= wr_be;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pipeline issue, repeat and latency timing
  logic [3*CFEU_TCNT_W-1:0] tim_cyc;
  logic [2:0]               tim_gate;
  logic [2:0]               tim_ok_nxt;
  logic [7:0]               last_id_r;
  logic                     same_id;

  // lanes: 0 issue, 1 repeat, 2 latency
  assign tim_cyc  = {latency_cyc, repeat_cyc, issue_cyc};
  // repeat waits only while the same instruction is presented again
  assign same_id  = (instr_id == last_id_r);
  assign tim_gate = {1'b1, same_id, 1'b1};

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      last_id_r <= 8'h00;
    end else if (instr_valid) begin
      last_id_r <= instr_id;
    end
  end

  generate
    for (genvar c = 0; c < 3; c++) begin : g_tim
      logic [CFEU_TCNT_W-1:0] cyc;
      logic [CFEU_TCNT_W-1:0] cnt_r;

      assign cyc = tim_cyc[c*CFEU_TCNT_W +: CFEU_TCNT_W];

      // a count of zero loads zero rather than wrapping
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          cnt_r <= '0;
        end else if (instr_valid) begin
          cnt_r <= (cyc == '0) ? '0 : cyc - 1'b1;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - 1'b1;
        end
      end

      assign tim_ok_nxt[c] = instr_valid ? (cyc <= 4'h1)
                                         : ((cnt_r <= 4'h1) | ~tim_gate[c]);
    end
  endgenerate

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      issue_ok_r  <= 1'b1;
      repeat_ok_r <= 1'b1;
      result_ok_r <= 1'b1;
    end else begin
      issue_ok_r  <= tim_ok_nxt[0];
      repeat_ok_r <= tim_ok_nxt[1];
      result_ok_r <= tim_ok_nxt[2];
    end
  end

endmodule

/* File: dv/cfeu_mem_model.sv */
`timescale 1ns/1ps
module cfeu_mem_model (
  input  wire logic        core_clk,
  input  wire logic        mem_rd,
  input  wire logic        bit_wr,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] store_data_r,
  input  wire logic [3:0]  store_be_r,
  input  wire logic        store_valid_r,
  output logic      [31:0] mem_rdata
);
  logic [31:0] mem [8];
  logic [2:0]  wa;
  // bus not read shows the inverted word
  assign mem_rdata = (mem_rd | bit_wr) ? mem[mem_addr[4:2]] : ~mem[mem_addr[4:2]];
  always_ff @(posedge core_clk) begin
    if (bit_wr | mem_wr)
      wa <= mem_addr[4:2];
    for (int i = 0; i < 4; i++)
      if (store_valid_r & store_be_r[i])
        mem[wa][8*i+:8] <= store_data_r[8*i+:8];
  end
endmodule

/* File: dv/cfeu_ref_pkg.sv */
package cfeu_ref_pkg;

  // expected condition outcome, flag order z s ov cy sat
  function automatic logic ev(logic [3:0] c, logic [4:0] f);
    logic t;
    case (c[2:0])
      3'h0: t = f[2];
      3'h1: t = f[3];
      3'h2: t = f[0];
      3'h3: t = f[3] | f[0];
      3'h4: t = f[1];
      3'h5: return c[3] ? f[4] : 1'b1;
      3'h6: t = f[1] ^ f[2];
      default: t = (f[1] ^ f[2]) | f[0];
    endcase
    return t ^ c[3];
  endfunction

  function automatic logic [31:0] ex(logic [31:0] d, logic [1:0] z, logic g);
    case (z)
      2'h0: return {{24{g & d[7]}}, d[7:0]};
      2'h1: return {{16{g & d[15]}}, d[15:0]};
      default: return d;
    endcase
  endfunction

  function automatic logic [31:0] ld(logic [31:0] w, logic [1:0] a, logic [1:0] z, logic g);
    logic [1:0] l;
    l = (z == 2'h0) ? a : (z == 2'h1) ? {a[1], 1'b0} : 2'h0;
    return ex(w >> {l, 3'h0}, z, g);
  endfunction

  function automatic logic [7:0] bs(logic [31:0] w, logic [1:0] a, logic [2:0] n, logic v);
    logic [7:0] b;
    b = w[{a, 3'h0}+:8];
    b[n] = v;
    return b;
  endfunction

  // clamp with hit flag on top
  function automatic logic [32:0] saturation_flag(logic [63:0] x);
    if ($signed(x) >= 64'sh7fffffff) return {1'b1, 32'h7fffffff};
    if ($signed(x) <= 64'shffffffff80000000) return {1'b1, 32'h80000000};
    return {1'b0, x[31:0]};
  endfunction

  function automatic logic [4:0] nf(logic [9:0] p, logic [4:0] o, r, s);
    logic [4:0] n;
    for (int i = 0; i < 5; i++) begin
      case (p[2*i+:2])
        2'h0: n[i] = o[i];
        2'h1: n[i] = 1'b0;
        2'h2: n[i] = r[i];
        default: n[i] = s[i];
      endcase
    end
    return n;
  endfunction

endpackage

/* File: dv/cfeu_top_asserts.sv */
`timescale 1ns/1ps
module cfeu_top_asserts
  import cfeu_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   reset,
  input wire logic [3:0]             cond_code,
  input wire logic                   cond_true_r,
  input wire logic                   flag_upd,
  input wire logic [9:0]             flag_policy,
  input wire logic [4:0]             result_flags,
  input wire logic                   flag_save,
  input wire logic [4:0]             flags_r,
  input wire logic [4:0]             saved_flags_r,
  input wire logic [63:0]            sat_in,
  input wire logic [31:0]            sat_out_r,
  input wire logic                   sat_hit_r,
  input wire logic                   mem_rd,
  input wire logic [31:0]            mem_addr,
  input wire logic [1:0]             mem_size,
  input wire logic                   mem_signed,
  input wire logic [31:0]            mem_rdata,
  input wire logic                   bit_wr,
  input wire logic [2:0]             bit_num,
  input wire logic                   bit_val,
  input wire logic [31:0]            load_data_r,
  input wire logic [31:0]            store_data_r,
  input wire logic [3:0]             store_be_r,
  input wire logic                   instr_valid,
  input wire logic [CFEU_TCNT_W-1:0] issue_cyc,
  input wire logic [CFEU_TCNT_W-1:0] repeat_cyc,
  input wire logic [CFEU_TCNT_W-1:0] latency_cyc,
  input wire logic [7:0]             instr_id,
  input wire logic                   load_zero_r,
  input wire logic                   issue_ok_r,
  input wire logic                   repeat_ok_r,
  input wire logic                   result_ok_r
);
  import cfeu_ref_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_cond_eval: assert property (!$past(reset) |->
    cond_true_r == ev($past(cond_code), $past(flags_r))) else $error("cond result wrong");
  a_sat_clamp: assert property (!$past(reset) |->
    {sat_hit_r, sat_out_r} == saturation_flag($past(sat_in))) else $error("clamp wrong");
  a_load_size: assert property (!$past(reset) && $past(mem_rd) |->
    load_data_r == ld($past(mem_rdata), $past(mem_addr[1:0]), $past(mem_size),
    $past(mem_signed))) else $error("load data wrong");
  a_bit_store: assert property (!$past(reset) && $past(bit_wr) |->
    store_be_r == 4'h1 << $past(mem_addr[1:0]) && store_data_r == {4{bs($past(mem_rdata),
    $past(mem_addr[1:0]), $past(bit_num), $past(bit_val))}}) else $error("bit store wrong");
  a_flag_update: assert property (!$past(reset) && $past(flag_upd) |->
    flags_r == nf($past(flag_policy), $past(flags_r), $past(result_flags),
    $past(saved_flags_r))) else $error("flag update wrong");
  a_flag_hold: assert property (!$past(reset) && !$past(flag_upd) |->
    $stable(flags_r)) else $error("flags moved");
  a_save_copy: assert property (!$past(reset) && $past(flag_save) |->
    saved_flags_r == $past(flags_r)) else $error("saved copy wrong");
  a_issue_wait: assert property (instr_valid && issue_cyc == 4'h3 |=>
    !issue_ok_r [*2] ##1 issue_ok_r) else $error("issue count wrong");
  a_issue_short: assert property (instr_valid && issue_cyc == 4'h0 ##1 !instr_valid |=>
    issue_ok_r) else $error("zero issue count wrong");
  a_result_wait: assert property (instr_valid && latency_cyc == 4'h3 |=>
    !result_ok_r [*2] ##1 result_ok_r) else $error("latency count wrong");
  a_repeat_wait: assert property (instr_valid && repeat_cyc == 4'h3 ##1
    !instr_valid && $stable(instr_id) |=> !repeat_ok_r ##1 repeat_ok_r)
    else $error("repeat count wrong");
  a_zero_bit: assert property (!$past(reset) && $past(mem_rd) |->
    load_zero_r != $past(mem_rdata[{mem_addr[1:0], bit_num}])) else $error("zero bit wrong");
endmodule

bind cfeu_top cfeu_top_asserts u_chk (.*);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top import cfeu_ref_pkg::*;;
  localparam logic [5:0] FU = 6'h20, FS = 6'h10, RD = 6'h08, WR = 6'h04, BW = 6'h02;
  logic core_clk, reset, flag_upd, flag_save, ext_signed, mem_rd, mem_wr, mem_signed;
  logic bit_wr, bit_val, instr_valid, cond_true_r, sat_hit_r, load_zero_r, store_valid_r;
  logic issue_ok_r, repeat_ok_r, result_ok_r;
  logic [3:0]  cond_code, store_be_r, issue_cyc, repeat_cyc, latency_cyc;
  logic [9:0]  flag_policy;
  logic [4:0]  result_flags, flags_r, saved_flags_r;
  logic [63:0] sat_in;
  logic [31:0] sat_out_r, ext_in, ext_out_r, mem_addr, mem_rdata, load_data_r, store_data_r;
  logic [1:0]  ext_size, mem_size;
  logic [2:0]  bit_num, due, due1;
  logic [7:0]  instr_id;
  logic [31:0] expq[$], sh[8], e;
  logic [63:0] sv[8] = '{64'h7fffffff, 64'h7ffffffe, 64'h80000000, 64'hffffffff80000000,
    64'hffffffff80000001, 64'hffffffff7fffffff, 64'h8000000000000000, 64'h1234abcd};
  int errors = 0, comparisons = 0, cyc = 0;

  cfeu_top u_dut (.*);
  cfeu_mem_model u_mem (.*);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic cmp_word(logic [31:0] g, logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic cmp_bit(logic g, logic x);
    cmp_word({31'h0, g}, {31'h0, x});
  endtask

  task automatic final_report;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one op per cycle, all strobes set together
  task automatic go(logic [5:0] s, logic [2:0] k, logic [31:0] x);
    {flag_upd, flag_save, mem_rd, mem_wr, bit_wr, instr_valid} <= s;
    due <= k;
    if (k != 3'h0)
      expq.push_back(x);
    @(posedge core_clk);
  endtask

  always @(posedge core_clk) due1 <= due;
  always @(negedge core_clk) begin
    if (due1 != 3'h0) begin
      e = expq.pop_front();
      case (due1)
        3'h1: cmp_bit(cond_true_r, e[0]);
        3'h2: cmp_word({27'h0, flags_r}, e);
        3'h3: cmp_word(sat_out_r, e);
        3'h4: cmp_word(ext_out_r, e);
        default: cmp_word(load_data_r, e);
      endcase
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      final_report;
    end
  end

  ////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [4:0]  fa, fb, fc;
    logic [9:0]  pl;
    logic [32:0] t;
    logic [1:0]  z;
    logic [3:0]  n;
    {reset, flag_upd, flag_save, ext_signed, mem_rd, mem_wr} = 6'h20;
    {mem_signed, bit_wr, bit_val, instr_valid, instr_id, bit_num} = '0;
    {cond_code, issue_cyc, repeat_cyc, latency_cyc, flag_policy, result_flags} = '0;
    {sat_in, ext_in, mem_addr, ext_size, mem_size, due} = '0;
    void'($urandom(31));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    for (int w = 0; w < 8; w++) begin
      r = $urandom;
      sh[w] = r;
      mem_addr <= {27'h0, w[2:0], 2'h0};
      mem_size <= 2'h2;
      ext_in <= r;
      go(WR, 3'h0, 32'h0);
    end
    for (int i = 0; i < 64; i++) begin
      fa = 5'($urandom);
      result_flags <= fa;
      flag_policy <= 10'h2aa;
      go(FU, 3'h2, {27'h0, fa});
      cond_code <= i[3:0];
      go(6'h0, 3'h1, {31'h0, ev(i[3:0], fa)});
    end
    for (int k = 0; k < 8; k++) begin
      {fa, fb, fc} = 15'($urandom);
      pl = (k < 4) ? {5{k[1:0]}} : 10'($urandom);
      flag_policy <= 10'h2aa;
      result_flags <= fa;
      go(FU, 3'h2, {27'h0, fa});
      go(FS, 3'h0, 32'h0);
      result_flags <= fb;
      go(FU, 3'h2, {27'h0, fb});
      flag_policy <= pl;
      result_flags <= fc;
      go(FU | FS, 3'h2, {27'h0, nf(pl, fb, fc, fa)});
    end
    for (int i = 0; i < 8; i++) begin
      sat_in <= sv[i];
      t = saturation_flag(sv[i]);
      go(6'h0, 3'h3, t[31:0]);
    end
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      z = 2'(i % 3);
      ext_in <= r;
      ext_size <= z;
      ext_signed <= i[0];
      go(6'h0, 3'h4, ex(r, z, i[0]));
    end
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      mem_addr <= {27'h0, r[4:0]};
      bit_num <= r[7:5];
      bit_val <= r[8];
      sh[r[4:2]][{r[1:0], r[7:5]}] = r[8];
      go(BW, 3'h0, 32'h0);
      go(6'h0, 3'h0, 32'h0);
      for (int j = 0; j < 3; j++) begin
        mem_size <= 2'(j);
        mem_signed <= r[9 + j];
        go(RD, 3'h5, ld(sh[r[4:2]], r[1:0], 2'(j), r[9 + j]));
      end
    end
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 4'h3 : (i == 1) ? 4'h0 : 4'($urandom);
      issue_cyc <= n;
      latency_cyc <= (i < 2) ? n : 4'($urandom);
      repeat_cyc <= (i < 2) ? n : 4'($urandom);
      instr_id <= 8'(i);
      go(6'h01, 3'h0, 32'h0);
      repeat (16) go(6'h0, 3'h0, 32'h0);
    end
    repeat (2) go(6'h0, 3'h0, 32'h0);
    final_report;
  end
endmodule
